// ==== include/bms_defines.svh ====
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH

// Boot pin codes, upper pin first
`define BMS_CODE_USER      2'h3
`define BMS_CODE_STD       2'h2
`define BMS_CODE_SEL       2'h1
`define BMS_CODE_RSVD      2'h0
`define BMS_ZERO_ADDR      24'h000000
`define BMS_ADDR_W         24
`define BMS_WORD_W         16
// Reserved signature locations and key location
`define BMS_SIG_ADDR0      24'h000100
`define BMS_SIG_ADDR1      24'h000102
`define BMS_KEY_ADDR       24'h000104
`define BMS_SIG_REF        16'hA5C3
// Key values selecting the boot channel
`define BMS_KEY_CAN        16'h00CA
// Receive lines idle high; start bit and dominant are low
`define BMS_LINE_ACTIVE    1'b0

`endif

// ==== include/bms_pkg.sv ====
package bms_pkg;
  typedef enum logic [1:0] {
    BMS_MODE_USER = 2'h0,
    BMS_MODE_STD  = 2'h1,
    BMS_MODE_SEL  = 2'h3
  } bms_mode_t;

  typedef enum logic [2:0] {
    BMS_ST_IDLE   = 3'h0,
    BMS_ST_RD0    = 3'h1,
    BMS_ST_RD1    = 3'h3,
    BMS_ST_CHECK  = 3'h2,
    BMS_ST_KEY    = 3'h6,
    BMS_ST_SCAN   = 3'h7,
    BMS_ST_DONE   = 3'h5
  } bms_state_t;

  typedef enum logic [1:0] {
    BMS_CH_NONE = 2'h0,
    BMS_CH_UART = 2'h1,
    BMS_CH_CAN  = 2'h2
  } bms_chan_t;
endpackage

// ==== src/bms_sync.sv ====
module bms_sync (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end else if (clk_en_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // bms_sync

// ==== src/bms_boot_mode_sel.sv ====
// Behaviour
// - Capture two boot pins at rising edge of external reset; hold as mode.
// - Both pins high: user mode, user flash at address zero.
// - Upper high, lower low: standard boot, fetches from zero go to test flash.
// - Upper low, lower high: selective boot with extra verification steps.
// - Selective boot redirects fetches to test flash, distinct sequence.
// - Selective boot compares signature of two flash words with reference.
// - Signature good: issue software reset and run user code in the same cycle.
// - Signature bad: reread key location, it picks the boot channel.
// - Standard boot watches UART and CAN receive lines for activity.
// - UART start condition seen first: run UART boot loader.
// - CAN dominant bit seen first: boot over CAN.
`include "bms_defines.svh"

module bms_boot_mode_sel (
  input  wire logic                        ref_clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        clk_en_i,
  input  wire logic                        external_reset_input_n_i,
  input  wire logic [1:0]                  boot_config_port_low_i,
  input  wire logic                        uart_receive_line_i,
  input  wire logic                        can_receive_line_i,
  output logic                             flash_rd_req_o,
  output logic [`BMS_ADDR_W-1:0]           flash_rd_addr_o,
  input  wire logic                        flash_rd_ack_i,
  input  wire logic [`BMS_WORD_W-1:0]      flash_rd_data_i,
  output bms_pkg::bms_mode_t               boot_mode_o,
  output logic [1:0]                       boot_code_o,
  output logic                             fetch_test_flash_o,
  output logic [`BMS_ADDR_W-1:0]           user_flash_base_o,
  output logic                             soft_reset_o,
  output logic                             run_user_o,
  output bms_pkg::bms_chan_t               boot_channel_o,
  output logic                             boot_ready_o
);
  import bms_pkg::*;

  logic                   rst_pin_s;
  logic                   uart_s;
  logic                   can_s;
  logic [1:0]             cfg_meta_q;
  logic [1:0]             cfg_s_q;
  logic                   rst_pin_d1_q;
  logic                   rst_rise;
  logic [1:0]             code_q;
  logic                   code_vld_q;
  bms_mode_t              mode_d;
  bms_mode_t              mode_q;
  bms_state_t             state_q;
  logic [`BMS_WORD_W-1:0] word0_q;
  logic [`BMS_WORD_W-1:0] word1_q;
  logic                   sig_ok;

  // Decode of a captured pin pair, reserved code falls to user mode
  function automatic bms_mode_t decode_mode(input logic [1:0] code);
    case (code)
      `BMS_CODE_USER: decode_mode = BMS_MODE_USER;
      `BMS_CODE_STD:  decode_mode = BMS_MODE_STD;
      `BMS_CODE_SEL:  decode_mode = BMS_MODE_SEL;
      default:        decode_mode = BMS_MODE_USER;
    endcase
  endfunction

  bms_sync u_rst_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (external_reset_input_n_i),
    .sync_o    (rst_pin_s)
  );

  bms_sync u_uart_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (uart_receive_line_i),
    .sync_o    (uart_s)
  );

  bms_sync u_can_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (can_receive_line_i),
    .sync_o    (can_s)
  );

  // Config pins pass two flops like the reset pin, but reset to 2'h0 where the reset pin sync resets high
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_meta_q <= 2'h0;
      cfg_s_q    <= 2'h0;
    end else if (clk_en_i) begin
      cfg_meta_q <= boot_config_port_low_i;
      cfg_s_q    <= cfg_meta_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Matches the synchroniser's reset level, so no false edge after reset
      rst_pin_d1_q <= 1'b1;
    end else if (clk_en_i) begin
      rst_pin_d1_q <= rst_pin_s;
    end
  end

  assign rst_rise = rst_pin_s & ~rst_pin_d1_q;

  // Pins latched only on the reset pin release
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_q     <= `BMS_CODE_USER;
      code_vld_q <= 1'b0;
    end else if (clk_en_i && rst_rise) begin
      code_q     <= cfg_s_q;
      code_vld_q <= 1'b1;
    end
  end

  assign mode_d = decode_mode(code_q);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= BMS_MODE_USER;
    end else if (clk_en_i) begin
      mode_q <= mode_d;
    end
  end

  assign boot_mode_o        = mode_q;
  assign boot_code_o        = code_q;
  assign fetch_test_flash_o = (mode_q != BMS_MODE_USER);
  assign user_flash_base_o  = `BMS_ZERO_ADDR;

  assign sig_ok = ((word0_q ^ word1_q) == `BMS_SIG_REF);

  // Boot sequencer, restarted by each reset pin release
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q         <= BMS_ST_IDLE;
      word0_q         <= '0;
      word1_q         <= '0;
      flash_rd_req_o  <= 1'b0;
      flash_rd_addr_o <= '0;
      soft_reset_o    <= 1'b0;
      run_user_o      <= 1'b0;
      boot_channel_o  <= BMS_CH_NONE;
      boot_ready_o    <= 1'b0;
    end else if (clk_en_i) begin
      soft_reset_o <= 1'b0;
      if (rst_rise) begin
        state_q        <= BMS_ST_IDLE;
        flash_rd_req_o <= 1'b0;
        run_user_o     <= 1'b0;
        boot_channel_o <= BMS_CH_NONE;
        boot_ready_o   <= 1'b0;
      end else begin
        case (state_q)
          BMS_ST_IDLE: begin
            if (code_vld_q && rst_pin_s) begin
              // Fresh decode: the mode register still holds the previous code here
              case (mode_d)
                BMS_MODE_SEL: begin
                  state_q         <= BMS_ST_RD0;
                  flash_rd_req_o  <= 1'b1;
                  flash_rd_addr_o <= `BMS_SIG_ADDR0;
                end
                BMS_MODE_STD: begin
                  state_q <= BMS_ST_SCAN;
                end
                default: begin
                  run_user_o   <= 1'b1;
                  boot_ready_o <= 1'b1;
                  state_q      <= BMS_ST_DONE;
                end
              endcase
            end
          end
          BMS_ST_RD0: begin
            if (flash_rd_ack_i) begin
              word0_q         <= flash_rd_data_i;
              flash_rd_addr_o <= `BMS_SIG_ADDR1;
              state_q         <= BMS_ST_RD1;
            end
          end
          BMS_ST_RD1: begin
            if (flash_rd_ack_i) begin
              word1_q        <= flash_rd_data_i;
              flash_rd_req_o <= 1'b0;
              state_q        <= BMS_ST_CHECK;
            end
          end
          BMS_ST_CHECK: begin
            if (sig_ok) begin
              soft_reset_o <= 1'b1;
              run_user_o   <= 1'b1;
              boot_ready_o <= 1'b1;
              state_q      <= BMS_ST_DONE;
            end else begin
              flash_rd_req_o  <= 1'b1;
              flash_rd_addr_o <= `BMS_KEY_ADDR;
              state_q         <= BMS_ST_KEY;
            end
          end
          BMS_ST_KEY: begin
            if (flash_rd_ack_i) begin
              flash_rd_req_o <= 1'b0;
              boot_ready_o   <= 1'b1;
              state_q        <= BMS_ST_DONE;
              boot_channel_o <= (flash_rd_data_i == `BMS_KEY_CAN) ? BMS_CH_CAN : BMS_CH_UART;
            end
          end
          BMS_ST_SCAN: begin
            // UART wins a tie; host is expected to use one channel only
            if (uart_s == `BMS_LINE_ACTIVE) begin
              boot_channel_o <= BMS_CH_UART;
              boot_ready_o   <= 1'b1;
              state_q        <= BMS_ST_DONE;
            end else if (can_s == `BMS_LINE_ACTIVE) begin
              boot_channel_o <= BMS_CH_CAN;
              boot_ready_o   <= 1'b1;
              state_q        <= BMS_ST_DONE;
            end
          end
          BMS_ST_DONE: begin
            state_q <= BMS_ST_DONE;
          end
          default: begin
            state_q <= BMS_ST_IDLE;
          end
        endcase
      end
    end
  end

  latch_on_rise_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && rst_rise |=> code_q == $past(cfg_s_q))
    else $error("boot code not latched at reset release");

  code_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !rst_rise |=> $stable(code_q))
    else $error("boot code changed without reset release");

  user_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    mode_q == BMS_MODE_USER |-> !fetch_test_flash_o && user_flash_base_o == `BMS_ZERO_ADDR)
    else $error("user mode fetch mapping wrong");

  std_decode_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && code_q == `BMS_CODE_STD |=> mode_q == BMS_MODE_STD && fetch_test_flash_o)
    else $error("standard boot decode wrong");

  sel_decode_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && code_q == `BMS_CODE_SEL |=> mode_q == BMS_MODE_SEL && fetch_test_flash_o)
    else $error("selective boot decode wrong");

  rsvd_decode_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && code_q == `BMS_CODE_RSVD |=> mode_q == BMS_MODE_USER)
    else $error("reserved code not defaulted to user");

  sig_pass_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !rst_rise && state_q == BMS_ST_CHECK && sig_ok |=> soft_reset_o && run_user_o)
    else $error("good signature did not reset into user code");

  sig_fail_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !rst_rise && state_q == BMS_ST_CHECK && !sig_ok
      |=> flash_rd_req_o && flash_rd_addr_o == `BMS_KEY_ADDR)
    else $error("bad signature did not reread key");

  uart_pick_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !rst_rise && state_q == BMS_ST_SCAN && !uart_s |=> boot_channel_o == BMS_CH_UART)
    else $error("uart start not taken");

  can_pick_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    clk_en_i && !rst_rise && state_q == BMS_ST_SCAN && uart_s && !can_s |=> boot_channel_o == BMS_CH_CAN)
    else $error("can dominant not taken");
endmodule // bms_boot_mode_sel

// ==== dv/bms_host_model.sv ====
`include "bms_defines.svh"

module bms_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        flash_rd_req_i,
  input  wire logic [23:0] flash_rd_addr_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic [15:0] sig0_i,
  input  wire logic [15:0] sig1_i,
  input  wire logic [15:0] key_i,
  input  wire logic [1:0]  host_i,
  output logic             flash_rd_ack_o,
  output logic [15:0]      flash_rd_data_o,
  output logic             uart_line_o,
  output logic             can_line_o,
  output int               reads_o
);
  logic [1:0] cnt_q;

  initial begin
    flash_rd_ack_o = 1'b0;
    flash_rd_data_o = 16'h0000;
    uart_line_o = 1'b1;
    can_line_o = 1'b1;
    reads_o = 0;
    cnt_q = 2'h0;
  end

  always @(negedge ref_clk_i) begin
    // Start bit or dominant level only once the host begins
    uart_line_o <= ~host_i[0];
    can_line_o <= ~host_i[1];
    if (flash_rd_req_i === 1'b1 && !flash_rd_ack_o && cnt_q >= wait_i) begin
      flash_rd_ack_o <= 1'b1;
      reads_o <= reads_o + 1;
      cnt_q <= 2'h0;
      case (flash_rd_addr_i)
        `BMS_SIG_ADDR0: flash_rd_data_o <= sig0_i;
        `BMS_SIG_ADDR1: flash_rd_data_o <= sig1_i;
        `BMS_KEY_ADDR: flash_rd_data_o <= key_i;
        default: flash_rd_data_o <= ~flash_rd_data_o;
      endcase
    end else begin
      // Data not held between answers
      flash_rd_ack_o <= 1'b0;
      flash_rd_data_o <= ~flash_rd_data_o;
      if (flash_rd_req_i === 1'b1) cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule // bms_host_model

// ==== dv/tb.sv ====
`include "bms_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bms_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ext_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [1:0]  code = 2'h3;
  logic [1:0]  host = 2'h0;
  logic [1:0]  wait_sel = 2'h0;
  logic [15:0] w0 = 16'h0000;
  logic [15:0] w1 = 16'h0000;
  logic [15:0] key = 16'h0000;
  logic        req, ack, uart, can, soft_reset_o, run_user_o, fetch_test_flash_o, boot_ready_o;
  logic [23:0] addr, base;
  logic [15:0] rdata;
  logic [1:0]  boot_code_o;
  bms_mode_t   boot_mode_o;
  bms_chan_t   boot_channel_o;
  int          reads;
  int          soft_cnt = 0;
  int          errors = 0;
  int          tests_run = 0;
  int          seed = 97450;

  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (soft_reset_o === 1'b1) soft_cnt <= soft_cnt + 1;

  bms_boot_mode_sel bms_boot_mode_sel_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .external_reset_input_n_i(ext_n), .boot_config_port_low_i(code), .uart_receive_line_i(uart),
    .can_receive_line_i(can), .flash_rd_req_o(req), .flash_rd_addr_o(addr), .flash_rd_ack_i(ack),
    .flash_rd_data_i(rdata), .boot_mode_o(boot_mode_o), .boot_code_o(boot_code_o),
    .fetch_test_flash_o(fetch_test_flash_o), .user_flash_base_o(base), .soft_reset_o(soft_reset_o),
    .run_user_o(run_user_o), .boot_channel_o(boot_channel_o), .boot_ready_o(boot_ready_o));

  bms_host_model bms_host_model_inst (.ref_clk_i(ref_clk_i), .flash_rd_req_i(req), .flash_rd_addr_i(addr),
    .wait_i(wait_sel), .sig0_i(w0), .sig1_i(w1), .key_i(key), .host_i(host), .flash_rd_ack_o(ack),
    .flash_rd_data_o(rdata), .uart_line_o(uart), .can_line_o(can), .reads_o(reads));

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic bms_mode_t exp_mode(input logic [1:0] c);
    case (c)
      `BMS_CODE_STD: return BMS_MODE_STD;
      `BMS_CODE_SEL: return BMS_MODE_SEL;
      default: return BMS_MODE_USER;
    endcase
  endfunction

  function automatic bms_chan_t exp_chan(input logic [1:0] c, input logic good, input logic [15:0] k,
                                         input logic [1:0] h);
    if (c == `BMS_CODE_STD) return h[0] ? BMS_CH_UART : BMS_CH_CAN;
    if (c == `BMS_CODE_SEL && !good) return (k == `BMS_KEY_CAN) ? BMS_CH_CAN : BMS_CH_UART;
    return BMS_CH_NONE;
  endfunction

  task automatic boot(input logic [1:0] c, input logic [15:0] a, input logic [15:0] b, input logic [15:0] k,
                      input logic [1:0] h);
    int   n;
    int   r0;
    int   s0;
    logic good;
    logic sel;
    @(negedge ref_clk_i);
    ext_n = 1'b0;
    code = c;
    w0 = a;
    w1 = b;
    key = k;
    host = 2'h0;
    wait_sel = 2'($random(seed));
    repeat (4) @(negedge ref_clk_i);
    ext_n = 1'b1;
    r0 = reads;
    s0 = soft_cnt;
    repeat (6) @(negedge ref_clk_i);
    host = h;
    n = 0;
    while (boot_ready_o !== 1'b1 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 300) begin
      errors++;
      tally_and_finish();
    end
    // Late line activity must not move the result
    host = ~h;
    repeat (4) @(negedge ref_clk_i);
    good = (a ^ b) == `BMS_SIG_REF;
    sel = c == `BMS_CODE_SEL;
    cmp(24'(boot_code_o), 24'(c));
    cmp(24'(boot_mode_o), 24'(exp_mode(c)));
    cmp(24'(fetch_test_flash_o), 24'(c == `BMS_CODE_STD || sel));
    cmp(base, `BMS_ZERO_ADDR);
    cmp(24'(run_user_o), 24'(c[0] == c[1] || (sel && good)));
    cmp(24'(soft_cnt - s0), 24'(sel && good));
    cmp(24'(reads - r0), sel ? (good ? 24'h2 : 24'h3) : 24'h0);
    cmp(24'(boot_channel_o), 24'(exp_chan(c, good, k, h)));
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] a;
    logic [1:0]  k;
    repeat (5) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    boot(2'h3, 16'h0000, 16'h0000, 16'h0000, 2'h1);
    boot(2'h0, 16'h0000, 16'h0000, 16'h0000, 2'h2);
    boot(2'h2, 16'h0000, 16'h0000, 16'h0000, 2'h1);
    boot(2'h2, 16'h0000, 16'h0000, 16'h0000, 2'h2);
    boot(2'h2, 16'h0000, 16'h0000, 16'h0000, 2'h3);
    boot(2'h1, 16'h1234, 16'h1234 ^ `BMS_SIG_REF, 16'h0000, 2'h1);
    boot(2'h1, 16'h1234, 16'h1234, `BMS_KEY_CAN, 2'h2);
    boot(2'h1, 16'hFFFF, 16'h0000, 16'h00CB, 2'h1);
    repeat (24) begin
      r = $random(seed);
      a = $random(seed);
      boot(r[1:0], a, r[2] ? a ^ `BMS_SIG_REF : r[31:16], r[3] ? `BMS_KEY_CAN : r[19:4],
           (r[5:4] == 2'h0) ? 2'h2 : r[5:4]);
    end
    // Frozen block must miss a full reset pin pulse
    k = code;
    clk_en = 1'b0;
    ext_n = 1'b0;
    code = ~k;
    repeat (6) @(negedge ref_clk_i);
    ext_n = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    clk_en = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    cmp(24'(boot_code_o), 24'(k));
    cmp(24'(boot_ready_o), 24'h1);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    cmp(24'(boot_ready_o), 24'h0);
    cmp(24'(boot_code_o), 24'h3);
    cmp(24'(boot_mode_o), 24'(BMS_MODE_USER));
    sys_rst_i = 1'b0;
    boot(2'h1, 16'h0F0F, 16'h0F0F ^ `BMS_SIG_REF, 16'h0000, 2'h1);
    tally_and_finish();
  end
endmodule // tb
